/* File: hw/i2csw_dev.sv */
// Purpose: serial slave and channel select register of the switch
// Assumes: link_clk runs free and far faster than the serial clock
// Notes:   lines are oversampled; reset pin and supply flag clear all
//
// Overview of operation
// - reset pin low clears register, state, channels
// - power-on reset starts all zero, channels off
// - each channel follows its own enable bit
// - data changes while clock high are conditions
// - one data bit per clock pulse
// - falling data, clock high: start, take address
// - rising data, clock high: stop, end transfer
// - transfers begin on an idle bus or with a repeated start
// - bytes are eight bits, msb first, plus ack
// - sender releases data before the ack slot
// - device acks every received byte, its own address too
// - controller acks each byte it reads unless the nack bit is set
// - acker holds data low across ack pulse
// - any number of bytes between start, stop
// - bits three to zero enable channels three to zero
// - new selection applies only after a stop
// - last written byte of a transfer is kept
// - last address bit: one read, zero write
`timescale 1ns/100ps
`default_nettype none
module i2csw_dev #(
  parameter logic [6:0]  SLAVE_ADDR = i2csw_pkg::DEV_ADDR_DEF,
  parameter int unsigned CHANNELS   = i2csw_pkg::CHANNELS
) (
  input  wire logic                link_clk,
  input  wire logic                reset_n,
  input  wire logic                power_on_threshold_ok,
  i2csw_if.dev                     bus,
  output logic      [CHANNELS-1:0] downstream_enable,
  output logic      [7:0]          ctrl_value
);
  import i2csw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    i2csw_dst_e          st;       // serial state
    logic [7:0]          sh;       // shift register, msb first
    logic [2:0]          cnt;      // bit counter within a byte
    logic                is_addr;  // byte being taken is the address
    logic                tx_next;  // after this ack, shift out a byte
    logic [7:0]          ctrl;     // channel select register
    logic [CHANNELS-1:0] en;       // connections actually made
    logic                sda_oe;   // pulling data low
    logic                scl_p;    // clock line, previous sample
    logic                sda_p;    // data line, previous sample
  } i2csw_dev_s;

  i2csw_dev_s q;         // registered state
  i2csw_dev_s d;         // next state
  logic       rst_n;     // combined reset, low active
  logic       scl_s;     // synchronised clock line
  logic       sda_s;     // synchronised data line
  logic       rise;      // clock line rose
  logic       fall;      // clock line fell
  logic       start_c;   // start condition seen
  logic       stop_c;    // stop condition seen

  ////////////////////////////////////////////////////////////////////////////
  // reset and line sampling
  // either source holds everything in reset; release is not synchronised,
  // which is safe because the bus is idle high when reset ends
  assign rst_n = reset_n & power_on_threshold_ok;

  i2csw_sync #(
    .W (2)
  ) u_sync (
    .clk   (link_clk),
    .rst_n (rst_n),
    .d     ({bus.scl, bus.sda}),
    .q     ({scl_s, sda_s})
  );

  // edges and bus conditions, all from synchronised samples
  assign rise    = scl_s & ~q.scl_p;
  assign fall    = ~scl_s & q.scl_p;
  // data moving while clock stays high is never data
  assign start_c = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign stop_c  = scl_s & q.scl_p & ~q.sda_p & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // serial state machine
  always_comb begin
    d       = q;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    if (start_c) begin
      // also a repeated start from any state
      d.st      = DS_RECV;
      d.cnt     = 3'h0;
      d.is_addr = 1'b1;
      d.sda_oe  = 1'b0;
    end else if (stop_c) begin
      // connect only now, when every line is high
      d.st     = DS_IDLE;
      d.sda_oe = 1'b0;
      d.en     = q.ctrl[CHANNELS-1:0];
    end else begin
      case (q.st)
        DS_RECV: begin
          // sample on the rising clock, one bit per pulse
          if (rise) begin
            d.sh  = {q.sh[6:0], sda_s};
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              d.st = DS_RXDONE;
            end
          end
        end
        DS_RXDONE: begin
          // eight bits in; answer after the clock falls
          if (fall) begin
            if (q.is_addr) begin
              if (q.sh[7:1] == SLAVE_ADDR) begin
                d.sda_oe  = 1'b1;
                d.st      = DS_ACK;
                d.tx_next = q.sh[0];
              end else begin
                d.st = DS_SKIP; // not ours, wait for a stop
              end
            end else begin
              d.ctrl    = q.sh;
              d.sda_oe  = 1'b1;
              d.st      = DS_ACK;
              d.tx_next = 1'b0;
            end
          end
        end
        DS_ACK: begin
          // data held low until the ack pulse has fallen again
          if (fall) begin
            d.cnt     = 3'h0;
            d.is_addr = 1'b0;
            if (q.tx_next) begin
              d.st     = DS_TX;
              d.sh     = q.ctrl;
              d.sda_oe = ~q.ctrl[7];
            end else begin
              d.st     = DS_RECV;
              d.sda_oe = 1'b0;
            end
          end
        end
        DS_TX: begin
          // new bit only while the clock is low
          if (rise) begin
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              d.st = DS_TXDONE;
            end
          end else if (fall) begin
            d.sh     = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
          end
        end
        DS_TXDONE: begin
          // hand the line over for the controller's ack
          if (fall) begin
            d.sda_oe = 1'b0;
            d.st     = DS_MACK;
          end
        end
        DS_MACK: begin
          // low means another byte, high ends the read
          if (rise) begin
            d.st = sda_s ? DS_SKIP : DS_ACK;
          end
        end
        default: begin
          // idle or unaddressed: only start or stop moves on
          // a data line stuck low never gives a stop; only reset frees it
          d.st = q.st;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; reset gives all zeros and lines seen high
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.st       <= DS_IDLE;
      q.ctrl     <= CTRL_RST;
      q.scl_p    <= 1'b1;
      q.sda_p    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // all straight from flip-flops, so no glitch reaches a channel
  assign downstream_enable = q.en;
  assign ctrl_value        = q.ctrl;
  assign bus.d_sda_oe      = q.sda_oe;
  assign bus.d_sda_o       = 1'b0; // open drain: only ever pulls low
endmodule : i2csw_dev
`default_nettype wire

/* File: hw/i2csw_host.sv */
// Purpose: serial bus controller run by software over APB
// Assumes: DIV register at least 4, device never stretches the clock
// Notes:   one operation at a time; each bit is four quarter phases
`timescale 1ns/100ps
`default_nettype none
module i2csw_host #(
  parameter logic [15:0] DIV_RESET = i2csw_pkg::DIV_RST
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  i2csw_if.host            bus
);
  import i2csw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [31:0] prdata;    // read data
    logic        pready;    // access phase answer
    logic        pslverr;   // unmapped address
    i2csw_op_e   op;        // running operation, none when idle
    logic        nack_cmd;  // value sent in the ack slot of a read
    logic [7:0]  txd;       // byte to send
    logic [7:0]  sh;        // transmit shift copy
    logic [7:0]  rxd;       // last byte read
    logic [15:0] div;       // quarter period minus one, in pclk cycles
    logic [15:0] cnt;       // quarter countdown
    logic [1:0]  ph;        // quarter phase within a slot
    logic [3:0]  slot;      // bit slot, ack at eight
    logic        got_nack;  // ack slot of last write was high
    logic        refused;   // start refused, bus not idle
    logic        owned;     // between our start and our stop
    logic        scl_oe;    // pulling clock low
    logic        sda_oe;    // pulling data low
  } i2csw_host_s;

  i2csw_host_s q;       // registered state
  i2csw_host_s d;       // next state
  logic        scl_s;   // synchronised clock line
  logic        sda_s;   // synchronised data line
  logic        setup;   // apb setup cycle
  logic        wr_done; // apb write completes at this edge
  logic        tick;    // quarter phase boundary
  logic        busy;    // an operation runs
  i2csw_op_e   new_op;  // op code being written

  i2csw_sync #(
    .W (2)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({bus.scl, bus.sda}),
    .q     ({scl_s, sda_s})
  );

  assign setup   = psel & ~penable;
  assign wr_done = psel & penable & q.pready & pwrite;
  assign tick    = (q.cnt == 16'h0000);
  assign busy    = (q.op != OP_NONE);
  assign new_op  = i2csw_op_e'(pwdata[2:0]);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave and serial engine
  always_comb begin
    d         = q;
    // one wait-free access: answer in the first access cycle
    d.pready  = setup;
    d.pslverr = 1'b0;
    if (setup) begin
      d.prdata = 32'h0000_0000;
      if (paddr == OFF_CMD) begin
        d.prdata[2:0] = q.op;
      end else if (paddr == OFF_TXD) begin
        d.prdata[7:0] = q.txd;
      end else if (paddr == OFF_STAT) begin
        d.prdata[STAT_BUSY]    = busy;
        d.prdata[STAT_NACK]    = q.got_nack;
        d.prdata[STAT_REFUSED] = q.refused;
        d.prdata[STAT_OWNED]   = q.owned;
        d.prdata[STAT_IDLE]    = scl_s & sda_s;
      end else if (paddr == OFF_RXD) begin
        d.prdata[7:0] = q.rxd;
      end else if (paddr == OFF_DIV) begin
        d.prdata[15:0] = q.div;
      end else begin
        d.pslverr = 1'b1;
      end
    end

    // serial engine, advances one quarter phase per tick
    if (busy) begin
      d.cnt = tick ? q.div : q.cnt - 16'h0001;
      if (tick) begin
        d.ph = q.ph + 2'h1;
        case (q.op)
          OP_START: begin
            case (q.ph)
              2'h0: d.sda_oe = 1'b0;
              2'h1: d.scl_oe = 1'b0;
              2'h2: d.sda_oe = 1'b1;
              default: begin
                d.scl_oe = 1'b1;
                d.op     = OP_NONE;
              end
            endcase
          end
          OP_STOP: begin
            case (q.ph)
              2'h0: begin
                d.scl_oe = 1'b1;
                d.sda_oe = 1'b1;
              end
              2'h1: d.scl_oe = 1'b0;
              2'h2: d.sda_oe = 1'b0;
              default: begin
                d.owned = 1'b0;
                d.op    = OP_NONE;
              end
            endcase
          end
          default: begin
            // write or read byte: nine slots of four phases
            case (q.ph)
              2'h0: begin
                // data moves only while the clock is low
                d.scl_oe = 1'b1;
                if (q.slot == ACK_SLOT) begin
                  d.sda_oe = (q.op == OP_READ) & ~q.nack_cmd;
                end else if (q.op == OP_WRITE) begin
                  d.sda_oe = ~q.sh[7];
                end else begin
                  d.sda_oe = 1'b0;
                end
                if ((q.slot == ACK_SLOT) && (q.op == OP_WRITE)) begin
                  d.sda_oe = 1'b0;
                end
              end
              2'h1: d.scl_oe = 1'b0;
              2'h2: begin
                // sample mid high phase, one bit per pulse
                if (q.slot == ACK_SLOT) begin
                  if (q.op == OP_WRITE) begin
                    d.got_nack = sda_s;
                  end
                end else if (q.op == OP_READ) begin
                  d.rxd = {q.rxd[6:0], sda_s};
                end
              end
              default: begin
                d.scl_oe = 1'b1;
                d.sh     = {q.sh[6:0], 1'b0};
                d.slot   = q.slot + 4'h1;
                if (q.slot == ACK_SLOT) begin
                  d.slot = 4'h0;
                  d.op   = OP_NONE;
                end
              end
            endcase
          end
        endcase
      end
    end

    // register writes; commands while busy are ignored
    if (wr_done) begin
      if (paddr == OFF_CMD) begin
        if (!busy && (new_op <= OP_READ) && (new_op != OP_NONE)) begin
          d.ph       = 2'h0;
          d.slot     = 4'h0;
          d.cnt      = q.div;
          d.sh       = q.txd;
          d.nack_cmd = pwdata[CMD_NACK_BIT];
          d.op       = new_op;
          d.refused  = 1'b0;
          if (new_op == OP_START) begin
            if (!q.owned && !(scl_s & sda_s)) begin
              d.op      = OP_NONE;
              d.refused = 1'b1;
            end else begin
              d.owned = 1'b1;
            end
          end
        end
      end else if (paddr == OFF_TXD) begin
        d.txd = pwdata[7:0];
      end else if (paddr == OFF_DIV) begin
        d.div = pwdata[15:0];
      end else begin
        d.div = q.div;
      end
      d.pslverr = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.op    <= OP_NONE;
      q.div   <= DIV_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign bus.m_scl_oe = q.scl_oe;
  assign bus.m_sda_oe = q.sda_oe;
  assign bus.m_scl_o  = 1'b0; // open drain: only ever pulls low
  assign bus.m_sda_o  = 1'b0;
endmodule : i2csw_host
`default_nettype wire

/* File: hw/i2csw_if.sv */
// Purpose: open-drain serial bus joining controller and device ends
// Assumes: pull-ups on both lines, modelled by the resolution below
// Notes:   an enabled driver pulls the line low only when its output value is low
`timescale 1ns/100ps
`default_nettype none
interface i2csw_if;
  logic m_scl_o;   // controller clock drive value
  logic m_scl_oe;  // controller clock drive enable
  logic m_sda_o;   // controller data drive value
  logic m_sda_oe;  // controller data drive enable
  logic d_sda_o;   // device data drive value
  logic d_sda_oe;  // device data drive enable
  logic scl;       // resolved clock line
  logic sda;       // resolved data line

  // wired-and of every enabled driver, high when nobody pulls
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

  modport host (input scl, input sda,
                output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
  modport dev  (input scl, input sda,
                output d_sda_o, output d_sda_oe);
endinterface : i2csw_if
`default_nettype wire

/* File: hw/i2csw_pkg.sv */
// Purpose: shared constants and types of the channel switch control pair
// Assumes: 50 MHz pclk on the controller end, free link clock on the device
// Notes:   controller register map and serial op codes live here
package i2csw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned PCLK_HZ     = 50_000_000; // controller clock
  localparam int unsigned SCL_HZ      = 100_000;    // default serial rate
  // quarter of a serial bit period in pclk cycles, rounded up
  localparam int unsigned QUARTER_CYC =
    (PCLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam logic [15:0] DIV_RST     = 16'(QUARTER_CYC);
  localparam int unsigned BYTE_BITS   = 8;          // bits before ack slot
  localparam logic [3:0]  ACK_SLOT    = 4'h8;       // ninth slot of a byte

  ////////////////////////////////////////////////////////////////////////////
  // device side
  localparam int unsigned CHANNELS     = 4;          // downstream pairs
  localparam logic [6:0]  DEV_ADDR_DEF = 7'h2a;      // arbitrary address
  localparam logic [7:0]  CTRL_RST     = 8'h00;      // no channel selected

  ////////////////////////////////////////////////////////////////////////////
  // controller register offsets (byte addresses)
  localparam logic [7:0] OFF_CMD  = 8'h00;
  localparam logic [7:0] OFF_TXD  = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_RXD  = 8'h0c;
  localparam logic [7:0] OFF_DIV  = 8'h10;

  // field positions
  localparam int unsigned CMD_NACK_BIT  = 8;  // ack value sent after a read
  localparam int unsigned STAT_BUSY     = 0;
  localparam int unsigned STAT_NACK     = 1;
  localparam int unsigned STAT_REFUSED  = 2;
  localparam int unsigned STAT_OWNED    = 3;
  localparam int unsigned STAT_IDLE     = 4;

  ////////////////////////////////////////////////////////////////////////////
  // controller serial operations
  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_START = 3'h1,
    OP_STOP  = 3'h2,
    OP_WRITE = 3'h3,
    OP_READ  = 3'h4
  } i2csw_op_e;

  // device serial states
  typedef enum logic [2:0] {
    DS_IDLE   = 3'h0,
    DS_RECV   = 3'h1,
    DS_RXDONE = 3'h2,
    DS_ACK    = 3'h3,
    DS_TX     = 3'h4,
    DS_TXDONE = 3'h5,
    DS_MACK   = 3'h6,
    DS_SKIP   = 3'h7
  } i2csw_dst_e;

endpackage : i2csw_pkg

/* File: hw/i2csw_sync.sv */
// Purpose: two-flop synchroniser for bus lines entering a clock domain
// Assumes: inputs are levels, idle high
// Notes:   resets to all ones so a reset never fakes a start condition
`timescale 1ns/100ps
`default_nettype none
module i2csw_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;  // first stage, read only by the second
    logic [W-1:0] out;   // second stage
  } i2csw_sync_s;

  i2csw_sync_s r_q;
  i2csw_sync_s r_d;

  // next state
  always_comb begin
    r_d.meta = d;
    r_d.out  = r_q.meta;
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '1;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.out;
endmodule : i2csw_sync
`default_nettype wire

/* File: tb/i2c_channel_switch_control_tb.sv */
// Purpose: software-level tests of controller and switch together
// Assumes: default slave address, DIV set to 4 for short runs
// Notes:   expectations come from the channel select rules, plus the DIV reset value and unmapped-address checks
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module i2c_channel_switch_control_tb;
  import i2csw_pkg::*;
  logic        pclk, presetn, link_clk, reset_n, pwr_ok;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, ctrl;
  logic [31:0] pwdata, prdata, rd, st;
  logic [3:0]  den;
  int          err_total, n_compared;
  logic [7:0]  pats [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'hf9, 8'h00, 8'hc5};
  i2csw_if bus_if();
  i2csw_host i2csw_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));
  i2csw_dev i2csw_dev_inst (.link_clk(link_clk), .reset_n(reset_n),
    .power_on_threshold_ok(pwr_ok), .bus(bus_if),
    .downstream_enable(den), .ctrl_value(ctrl));
  i2csw_properties i2csw_properties_inst (.link_clk(link_clk),
    .reset_n(reset_n), .power_on_threshold_ok(pwr_ok), .pclk(pclk),
    .presetn(presetn), .scl(bus_if.scl), .sda(bus_if.sda),
    .m_sda_oe(bus_if.m_sda_oe), .d_sda_oe(bus_if.d_sda_oe),
    .downstream_enable(den), .ctrl_value(ctrl));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // link clock phase offset keeps the domains unrelated
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // issue a serial op and poll until the controller is free again
  task automatic op(input logic [31:0] c);
    int n;
    apb(1'b1, OFF_CMD, c);
    n = 0;
    do begin
      apb(1'b0, OFF_STAT, 32'h0);
      st = rd;
      n++;
    end while (st[STAT_BUSY] !== 1'b0 && n < 500);
    if (st[STAT_BUSY] !== 1'b0) err_total++;
  endtask : op
  task automatic wrb(input logic [7:0] b);
    apb(1'b1, OFF_TXD, {24'h0, b});
    op({29'h0, OP_WRITE});
    `CHK(st[STAT_NACK], 1'b0)
  endtask : wrb
  task automatic rdb(input logic nk, input logic [7:0] e);
    op({23'h0, nk, 5'h0, OP_READ});
    apb(1'b0, OFF_RXD, 32'h0);
    `CHK(rd, {24'h0, e})
  endtask : rdb
  // one complete selection write, then the stop that applies it
  task automatic sel(input logic [7:0] v);
    op({29'h0, OP_START});
    wrb({DEV_ADDR_DEF, 1'b0});
    wrb(v);
    op({29'h0, OP_STOP});
    repeat (4) @(posedge pclk);
    `CHK(den, v[3:0])
  endtask : sel
  task end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////
  // watchdog sized well above the few thousand cycles the tests use
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    end_of_test();
  end
  initial begin
    {presetn, reset_n, pwr_ok, psel, penable, pwrite} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    {presetn, reset_n, pwr_ok} <= 3'h7;
    @(posedge pclk);
    `CHK(den, 4'h0)
    `CHK(ctrl, 8'h00)
    apb(1'b0, OFF_DIV, 32'h0);
    `CHK(rd, {16'h0, DIV_RST})
    apb(1'b1, OFF_DIV, 32'h4);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(err, 1'b1)
    $display("test registers done");
    // several bytes: last one kept, enables wait for the stop
    op({29'h0, OP_START});
    wrb({DEV_ADDR_DEF, 1'b0});
    wrb(8'h35);
    wrb(8'h06);
    `CHK(ctrl, 8'h06)
    `CHK(den, 4'h0)
    op({29'h0, OP_STOP});
    repeat (4) @(posedge pclk);
    `CHK(den, 4'h6)
    $display("test multi byte done");
    // each channel alone, a combination, none, then a mixed pattern
    foreach (pats[i]) sel(pats[i]);
    $display("test channel select done");
    // read back twice, acked then refused, selection unchanged
    op({29'h0, OP_START});
    wrb({DEV_ADDR_DEF, 1'b1});
    rdb(1'b0, 8'hc5);
    rdb(1'b1, 8'hc5);
    op({29'h0, OP_STOP});
    repeat (4) @(posedge pclk);
    `CHK(den, 4'h5)
    $display("test read done");
    // reset pin in mid-run, then the supply flag
    reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({den, ctrl}, 12'h000)
    reset_n <= 1'b1;
    repeat (2) @(posedge pclk);
    sel(8'h0a);
    pwr_ok <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({den, ctrl}, 12'h000)
    pwr_ok <= 1'b1;
    repeat (2) @(posedge pclk);
    sel(8'h03);
    $display("test resets done");
    end_of_test();
  end
endmodule : i2c_channel_switch_control_tb
`default_nettype wire

/* File: tb/i2csw_properties.sv */
// Purpose: concurrent checks on the serial link between both ends
// Assumes: both ends use the default slave address
// Notes:   helper logic counts scl rises since the last start
`timescale 1ns/100ps
`default_nettype none
module i2csw_properties (
  input wire logic       link_clk,
  input wire logic       reset_n,
  input wire logic       power_on_threshold_ok,
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       m_sda_oe,
  input wire logic       d_sda_oe,
  input wire logic [3:0] downstream_enable,
  input wire logic [7:0] ctrl_value
);
  ////////////////////////////////////////////////////////////////////////
  logic       rst_n;    // either device reset source
  logic       rise;     // scl rising at this sample
  logic       start;    // start condition seen
  logic       stop;     // stop condition seen
  logic [2:0] bidx;     // bit index inside a read byte
  logic [3:0] bcnt_q;   // rises since start, wraps 9 to 1
  logic [3:0] since_q;  // samples since last stop, saturating
  logic       first_q;  // address byte in flight
  logic       rd_q;     // direction bit of the address
  logic       nak_q;    // controller refused a read byte
  logic       pscl_q;
  logic       psda_q;
  assign rst_n = reset_n & power_on_threshold_ok;
  assign rise  = scl & ~pscl_q;
  assign start = scl & pscl_q & psda_q & ~sda;
  assign stop  = scl & pscl_q & ~psda_q & sda;
  assign bidx  = (bcnt_q == 4'h9) ? 3'h0 : bcnt_q[2:0];

  // track framing on the raw lines; idle-high reset avoids false start
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      {bcnt_q, first_q, rd_q, nak_q} <= 7'h00;
      {pscl_q, psda_q} <= 2'h3;
      since_q <= 4'hf;
    end else begin
      pscl_q  <= scl;
      psda_q  <= sda;
      since_q <= stop ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
      if (start) begin
        {bcnt_q, first_q, rd_q, nak_q} <= 7'h04;
      end else if (rise) begin
        bcnt_q <= (bcnt_q == 4'h9) ? 4'h1 : bcnt_q + 4'h1;
        if (first_q && bcnt_q == 4'h7) rd_q <= sda;
        if (bcnt_q == 4'h8) begin
          first_q <= 1'b0;
          if (rd_q && !first_q && sda) nak_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ninth rise of a byte the device must accept
  sequence s_rx_ack;
    rise && bcnt_q == 4'h8 && (first_q || !rd_q);
  endsequence
  sequence s_rd_bit;
    rise && rd_q && !first_q && !nak_q && bcnt_q != 4'h8;
  endsequence

  chk_ack_rx_byte: assert property (@(posedge link_clk)
    disable iff (!rst_n) s_rx_ack |-> (!sda && d_sda_oe)[*8])
    else $error("ack missing");
  chk_read_msb_first: assert property (@(posedge link_clk)
    disable iff (!rst_n) s_rd_bit |-> sda == ctrl_value[3'h7 - bidx])
    else $error("read bit wrong");
  chk_enable_at_stop: assert property (@(posedge link_clk)
    disable iff (!rst_n) stop |->
    ##[1:12] downstream_enable == ctrl_value[3:0])
    else $error("selection not applied");
  chk_enable_waits: assert property (@(posedge link_clk)
    disable iff (!rst_n) $changed(downstream_enable) |-> since_q <= 4'hc)
    else $error("selection changed without stop");
  chk_dev_data_stable: assert property (@(posedge link_clk)
    disable iff (!rst_n) scl && pscl_q |-> $stable(d_sda_oe))
    else $error("device data moved in clock high");
  chk_sender_release: assert property (@(posedge link_clk)
    disable iff (!rst_n) scl |-> !(d_sda_oe && m_sda_oe))
    else $error("both ends drive data");
  chk_reset_pin_clear: assert property (@(posedge link_clk)
    !reset_n |-> downstream_enable == 4'h0 && ctrl_value == 8'h00 && !d_sda_oe)
    else $error("reset pin left state");
  chk_power_on_clear: assert property (@(posedge link_clk)
    !power_on_threshold_ok |-> downstream_enable == 4'h0 && !d_sda_oe)
    else $error("power-on reset left state");
  chk_clock_pulse: assert property (@(posedge pclk)
    disable iff (!presetn) $rose(scl) |-> scl[*8])
    else $error("clock pulse too short");
endmodule : i2csw_properties
`default_nettype wire
